// *** logic/farc_top.sv ***
`timescale 1ns/1ps
`include "farc_cfg.svh"

module farc_top #(
    parameter int unsigned TICK_CYCLES = `FARC_TICK_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_fault_active,
    input  wire logic [3:0]  i_fault_code,
    input  wire logic        i_output_block,
    input  wire logic        i_manual_reset,
    input  wire logic [3:0]  i_restart_attempt_limit,
    input  wire logic        i_relay_during_retry_select,
    input  wire logic [10:0] i_restart_interval_time,
    input  wire logic        i_fixed_interval_variant,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    output logic             o_auto_reset,
    output logic             o_fault_relay_contacts,
    output logic             o_fault_latched,
    output logic      [3:0]  o_restart_count,
    output logic             o_retry_pending
);

    localparam logic [3:0]  LIMIT_MAX = 4'(`FARC_LIMIT_MAX);
    localparam logic [10:0] IV_MIN    = 11'(`FARC_INTERVAL_MIN_MS / `FARC_TICK_MS);
    localparam logic [10:0] IV_MAX    = 11'(`FARC_INTERVAL_MAX_MS / `FARC_TICK_MS);
    localparam logic [10:0] IV_FIXED  = 11'(`FARC_FIXED_TICKS);

    farc_pkg::farc_top_st_t q;
    farc_pkg::farc_top_st_t d;

    logic [3:0]  lim;
    logic [10:0] iv_ticks;
    logic        uv_always;
    logic        is_uv;
    logic        eligible;
    logic        retry_ok;
    logic        tmr_start;
    logic        tmr_done;

    // settings outside the legal span are pulled to the nearest bound
    assign lim = (i_restart_attempt_limit > LIMIT_MAX) ? LIMIT_MAX : i_restart_attempt_limit;
    always_comb begin
        if (i_fixed_interval_variant) begin
            iv_ticks = IV_FIXED;
        end else if (i_restart_interval_time < IV_MIN) begin
            iv_ticks = IV_MIN;
        end else if (i_restart_interval_time > IV_MAX) begin
            iv_ticks = IV_MAX;
        end else begin
            iv_ticks = i_restart_interval_time;
        end
    end

    assign uv_always = q.uvsel[`FARC_UVSEL_BIT];
    assign is_uv     = (i_fault_code == farc_pkg::FARC_F_UV);
    assign eligible  = (i_fault_code <= farc_pkg::FARC_F_SE3) || is_uv;
    assign retry_ok  = (is_uv && uv_always) || (eligible && lim != 4'h0 && q.count < lim);

    assign tmr_start = (q.state == farc_pkg::FARC_ST_WAIT_BB) && i_output_block;

    farc_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_start   (tmr_start),
        .i_ticks   (iv_ticks),
        .o_busy    (),
        .o_done    (tmr_done)
    );

    always_comb begin
        d            = q;
        d.auto_reset = 1'b0;
        unique case (q.state)
            farc_pkg::FARC_ST_IDLE: begin
                if (i_manual_reset) begin
                    d.count = `FARC_COUNT_RESET;
                end
                if (i_fault_active) begin
                    d.latched = 1'b1;
                    d.uv_evt  = is_uv;
                    d.state   = retry_ok ? farc_pkg::FARC_ST_WAIT_BB : farc_pkg::FARC_ST_LOCKED;
                end
            end
            farc_pkg::FARC_ST_WAIT_BB: begin
                if (i_output_block) begin
                    d.state = farc_pkg::FARC_ST_WAIT_INT;
                end
            end
            farc_pkg::FARC_ST_WAIT_INT: begin
                if (tmr_done) begin
                    d.auto_reset = 1'b1;
                    d.latched    = 1'b0;
                    d.state      = farc_pkg::FARC_ST_RESET;
                    if (!(q.uv_evt && uv_always)) begin
                        d.count = q.count + 4'h1;
                    end
                end
            end
            // one idle cycle lets the detector drop the fault before it is looked at again
            farc_pkg::FARC_ST_RESET: begin
                d.state = farc_pkg::FARC_ST_IDLE;
            end
            farc_pkg::FARC_ST_LOCKED: begin
                if (i_manual_reset) begin
                    d.latched = 1'b0;
                    d.count   = `FARC_COUNT_RESET;
                    d.state   = farc_pkg::FARC_ST_IDLE;
                end
            end
            default: begin
                d.state = farc_pkg::FARC_ST_IDLE;
            end
        endcase

        unique case (d.state)
            farc_pkg::FARC_ST_IDLE: d.relay = 1'b0;
            farc_pkg::FARC_ST_LOCKED: d.relay = 1'b1;
            default: d.relay = i_relay_during_retry_select || (lim != 4'h0 && d.count >= lim);
        endcase

        // the select is written in any state, so a write during a retry already decides whether that retry is counted
        if (i_reg_wr && i_reg_addr == `FARC_UVSEL_OFFSET) begin
            d.uvsel = i_reg_wdata;
        end
        d.rdata = (i_reg_addr == `FARC_UVSEL_OFFSET) ? q.uvsel : 16'h0000;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q <= '{state: farc_pkg::FARC_ST_IDLE, count: `FARC_COUNT_RESET, uv_evt: 1'b0, latched: 1'b0,
                   relay: 1'b0, auto_reset: 1'b0, uvsel: `FARC_UVSEL_RESET, rdata: 16'h0000};
        end else begin
            q <= d;
        end
    end

    assign o_reg_rdata            = q.rdata;
    assign o_auto_reset           = q.auto_reset;
    assign o_fault_relay_contacts = q.relay;
    assign o_fault_latched        = q.latched;
    assign o_restart_count        = q.count;
    assign o_retry_pending        = (q.state == farc_pkg::FARC_ST_WAIT_BB) || (q.state == farc_pkg::FARC_ST_WAIT_INT);

    // helper for the interval check
    logic [31:0] h_cnt;
    logic [10:0] h_ticks;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            h_cnt   <= 32'h00000000;
            h_ticks <= 11'h000;
        end else if (tmr_start) begin
            h_cnt   <= 32'h00000000;
            h_ticks <= iv_ticks;
        end else begin
            h_cnt   <= h_cnt + 32'h00000001;
        end
    end

    a_interval_exact: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_auto_reset |-> h_cnt == 32'(h_ticks) * TICK_CYCLES + 32'h00000001)
        else $error("auto reset not at the interval end");

    a_block_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.state == farc_pkg::FARC_ST_WAIT_BB && !i_output_block) |=> !o_auto_reset && !tmr_done)
        else $error("auto reset before output block");

    a_relay_retry: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.state == farc_pkg::FARC_ST_WAIT_INT && q.count < lim && $stable(i_relay_during_retry_select))
        |-> o_fault_relay_contacts == i_relay_during_retry_select)
        else $error("relay does not follow retry select");

    a_relay_limit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.state != farc_pkg::FARC_ST_IDLE && lim != 4'h0 && q.count >= lim && $stable(lim))
        |-> o_fault_relay_contacts)
        else $error("relay off with limit reached");

    a_uv_uncounted: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (o_auto_reset && q.uv_evt && uv_always) |-> o_restart_count == $past(o_restart_count))
        else $error("undervoltage retry was counted");

    a_count_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (o_auto_reset && !(q.uv_evt && uv_always)) |-> o_restart_count == $past(o_restart_count) + 4'h1)
        else $error("retry count did not step by one");

    a_other_locked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.state == farc_pkg::FARC_ST_IDLE && i_fault_active && !eligible)
        |=> q.state == farc_pkg::FARC_ST_LOCKED ##1 !o_auto_reset)
        else $error("non retryable fault not locked");

    a_relay_factory: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.state == farc_pkg::FARC_ST_WAIT_BB && i_relay_during_retry_select && $stable(i_relay_during_retry_select))
        |-> o_fault_relay_contacts)
        else $error("relay open during restart with select set");

    a_zero_disable: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.state == farc_pkg::FARC_ST_IDLE && i_fault_active && lim == 4'h0 && !(is_uv && uv_always))
        |=> q.state == farc_pkg::FARC_ST_LOCKED)
        else $error("retry taken with zero limit");

    a_lock_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.state == farc_pkg::FARC_ST_LOCKED && !i_manual_reset)
        |=> q.state == farc_pkg::FARC_ST_LOCKED && o_fault_latched && !o_auto_reset)
        else $error("locked fault released without manual reset");

endmodule : farc_top

// *** logic/farc_cfg.svh ***
`ifndef FARC_CFG_SVH
`define FARC_CFG_SVH

`define FARC_UVSEL_OFFSET      16'h04cc
`define FARC_UVSEL_RESET       16'h0000
`define FARC_UVSEL_BIT         0
`define FARC_COUNT_RESET       4'h0

`define FARC_CLK_HZ            25000000
`define FARC_TICK_MS           100
`define FARC_TICK_CYCLES       (`FARC_CLK_HZ / 1000 * `FARC_TICK_MS)
`define FARC_FIXED_INTERVAL_MS 2000
`define FARC_FIXED_TICKS       (`FARC_FIXED_INTERVAL_MS / `FARC_TICK_MS)
`define FARC_INTERVAL_MIN_MS   500
`define FARC_INTERVAL_MAX_MS   180000
`define FARC_INTERVAL_DEF_MS   2000

`define FARC_LIMIT_MAX         10
`define FARC_LIMIT_DEF         2
`define FARC_RELAY_SEL_DEF     1

`endif

// *** logic/farc_pkg.sv ***
package farc_pkg;

    typedef enum logic [3:0] {
        FARC_F_OV    = 4'h0,
        FARC_F_GF    = 4'h1,
        FARC_F_OC    = 4'h2,
        FARC_F_OL2   = 4'h3,
        FARC_F_OL3   = 4'h4,
        FARC_F_OL4   = 4'h5,
        FARC_F_UL3   = 4'h6,
        FARC_F_UL4   = 4'h7,
        FARC_F_PF    = 4'h8,
        FARC_F_LF    = 4'h9,
        FARC_F_SE1   = 4'ha,
        FARC_F_SE2   = 4'hb,
        FARC_F_SE3   = 4'hc,
        FARC_F_UV    = 4'hd,
        FARC_F_OTHER = 4'he,
        FARC_F_SPARE = 4'hf
    } farc_fault_t;

    typedef enum logic [2:0] {
        FARC_ST_IDLE     = 3'b000,
        FARC_ST_WAIT_BB  = 3'b001,
        FARC_ST_WAIT_INT = 3'b010,
        FARC_ST_RESET    = 3'b011,
        FARC_ST_LOCKED   = 3'b100
    } farc_state_t;

    typedef struct packed {
        farc_state_t state;
        logic [3:0]  count;
        logic        uv_evt;
        logic        latched;
        logic        relay;
        logic        auto_reset;
        logic [15:0] uvsel;
        logic [15:0] rdata;
    } farc_top_st_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [21:0] pre;
        logic [10:0] ticks;
    } farc_tmr_st_t;

endpackage : farc_pkg

// *** logic/farc_timer.sv ***
`timescale 1ns/1ps
`include "farc_cfg.svh"

module farc_timer #(
    parameter int unsigned TICK_CYCLES = `FARC_TICK_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [10:0] i_ticks,
    output logic             o_busy,
    output logic             o_done
);

    localparam logic [21:0] PRE_LOAD = 22'(TICK_CYCLES - 1);

    farc_pkg::farc_tmr_st_t q;
    farc_pkg::farc_tmr_st_t d;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (i_start) begin
            d.busy  = 1'b1;
            d.pre   = PRE_LOAD;
            d.ticks = (i_ticks == 11'h000) ? 11'h001 : i_ticks;
        end else if (q.busy) begin
            if (q.pre == 22'h000000) begin
                d.pre = PRE_LOAD;
                if (q.ticks == 11'h001) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end else begin
                    d.ticks = q.ticks - 11'h001;
                end
            end else begin
                d.pre = q.pre - 22'h000001;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_busy = q.busy;
    assign o_done = q.done;

    a_done_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_done |=> !o_done) else $error("timer done held longer than one cycle");

endmodule : farc_timer

// *** verif/farc_fault_model.sv ***
`timescale 1ns/1ps

module farc_fault_model #(
    parameter int unsigned BB_DELAY = 8
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_raise,
    input  wire logic [3:0] i_code,
    input  wire logic       i_auto_reset,
    input  wire logic       i_manual_reset,
    output logic            o_fault_active,
    output logic      [3:0] o_fault_code,
    output logic            o_output_block
);
    int unsigned age;

    initial begin
        age = 0;
        o_fault_active = 1'b0;
        o_fault_code = 4'h0;
        o_output_block = 1'b0;
    end

    // block lags the fault on purpose, so an auto reset taken too early shows
    // driven by nonblocking assignment on the edge so the bench never races it
    always @(posedge i_ref_clk) begin
        if (i_auto_reset || i_manual_reset) begin
            o_fault_active <= 1'b0;
            o_output_block <= 1'b0;
        end else if (i_raise) begin
            o_fault_active <= 1'b1;
            o_fault_code   <= i_code;
            o_output_block <= 1'b0;
            age            <= 1;
        end else if (o_fault_active) begin
            age            <= age + 1;
            o_output_block <= ((age + 1) > BB_DELAY);
        end else begin
            o_fault_code <= ~o_fault_code;
        end
    end
endmodule : farc_fault_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        raise = 1'b0;
    logic [3:0]  code = 4'h0;
    logic        mrst = 1'b0;
    logic [3:0]  limit = 4'h2;
    logic        rsel = 1'b1;
    logic [10:0] ival = 11'h002;
    logic        fixed = 1'b0;
    logic [15:0] addr = 16'h04cc;
    logic        wr = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic        fact;
    logic [3:0]  fcode;
    logic        oblk;
    logic        ares;
    logic        relay;
    logic        latched;
    logic [3:0]  rcount;
    logic        pending;
    logic [15:0] d;
    int          fails = 0;
    int          comparisons = 0;

    always #20 clk = ~clk;

    farc_top #(.TICK_CYCLES(4)) farc_top_inst (
        .i_ref_clk(clk), .i_rst(rst), .i_fault_active(fact), .i_fault_code(fcode),
        .i_output_block(oblk), .i_manual_reset(mrst), .i_restart_attempt_limit(limit),
        .i_relay_during_retry_select(rsel), .i_restart_interval_time(ival),
        .i_fixed_interval_variant(fixed), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_auto_reset(ares), .o_fault_relay_contacts(relay),
        .o_fault_latched(latched), .o_restart_count(rcount), .o_retry_pending(pending)
    );

    farc_fault_model farc_fault_model_inst (
        .i_ref_clk(clk), .i_raise(raise), .i_code(code), .i_auto_reset(ares),
        .i_manual_reset(mrst), .o_fault_active(fact), .o_fault_code(fcode), .o_output_block(oblk)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic reg_wr(input logic [15:0] a, input logic [15:0] v);
        addr = a;
        wdata = v;
        wr = 1'b1;
        tick();
        wr = 1'b0;
        tick();
    endtask : reg_wr

    task automatic reg_rd(input logic [15:0] a, output logic [15:0] v);
        addr = a;
        tick();
        v = rdata;
    endtask : reg_rd

    // t = interval ticks expected, 0 when the fault must stay latched
    task automatic run_fault(input logic [3:0] c, input int t, input logic [3:0] cnt, input logic rl);
        int   n;
        logic bb;
        logic go;
        logic seen;
        n = 0;
        go = 1'b0;
        seen = 1'b0;
        code = c;
        raise = 1'b1;
        tick();
        raise = 1'b0;
        repeat (2) tick();
        check(latched, 1'b1);
        check(relay, rl);
        check(pending, 1'(t != 0));
        if (t == 0) begin
            repeat (60) begin
                tick();
                seen = seen | ares;
            end
            check(seen, 1'b0);
            check(latched, 1'b1);
            check(relay, 1'b1);
            check(rcount, cnt);
            mrst = 1'b1;
            tick();
            mrst = 1'b0;
            repeat (2) tick();
            check(latched, 1'b0);
            check(rcount, 4'h0);
        end else begin
            for (int k = 0; k < 8000 && ares !== 1'b1; k++) begin
                bb = oblk;
                tick();
                if (go) n++;
                if (bb && !go) go = 1'b1;
            end
            check(ares, 1'b1);
            check(16'(n), 16'(t * 4 + 1));
            check(latched, 1'b0);
            check(rcount, cnt);
            repeat (2) tick();
            check(relay, 1'b0);
            check(pending, 1'b0);
        end
    endtask : run_fault

    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        reg_rd(16'h04cc, d);
        check(d, 16'h0000);
        check(rcount, 4'h0);
        reg_wr(16'h04cc, 16'ha5a5);
        reg_rd(16'h04cc, d);
        check(d, 16'ha5a5);
        reg_wr(16'h04ce, 16'h0001);
        reg_rd(16'h04ce, d);
        check(d, 16'h0000);
        reg_wr(16'h04cc, 16'h0000);
        // below-range interval clamps to 0.5 s
        run_fault(4'h2, 5, 4'h1, 1'b1);
        fixed = 1'b1;
        rsel = 1'b0;
        run_fault(4'h1, 20, 4'h2, 1'b0);
        fixed = 1'b0;
        run_fault(4'h0, 0, 4'h2, 1'b1);
        limit = 4'hf;
        for (int k = 0; k < 10; k++) run_fault(4'(k), 5, 4'(k + 1), 1'b0);
        run_fault(4'ha, 0, 4'ha, 1'b1);
        run_fault(4'he, 0, 4'h0, 1'b1);
        run_fault(4'hf, 0, 4'h0, 1'b1);
        for (int k = 10; k < 13; k++) run_fault(4'(k), 5, 4'(k - 9), 1'b0);
        limit = 4'h0;
        run_fault(4'h2, 0, 4'h3, 1'b1);
        reg_wr(16'h04cc, 16'h0001);
        run_fault(4'hd, 5, 4'h0, 1'b0);
        limit = 4'h2;
        ival = 11'h007;
        run_fault(4'hd, 7, 4'h0, 1'b0);
        run_fault(4'h2, 7, 4'h1, 1'b0);
        run_fault(4'hd, 7, 4'h1, 1'b0);
        run_fault(4'h2, 7, 4'h2, 1'b0);
        run_fault(4'hd, 7, 4'h2, 1'b1);
        run_fault(4'h2, 0, 4'h2, 1'b1);
        reg_wr(16'h04cc, 16'h0000);
        run_fault(4'hd, 7, 4'h1, 1'b0);
        rsel = 1'b1;
        ival = 11'h7d0;
        run_fault(4'h2, 1800, 4'h2, 1'b1);
        summarize();
    end
endmodule : testbench
